// ---- rtl/psb_pkg.sv ----
// Shared constants and types of the pipelined burst SRAM port
package psb_pkg;

   //--------------------------------------------------------------
   // Array geometry
   //--------------------------------------------------------------
   localparam int ADDR_W  = 19;
   localparam int DATA_W  = 36;
   localparam int LANES   = 4;
   localparam int LANE_W  = 9;
   localparam int BURST_W = 2;
   localparam int DEPTH   = 1 << ADDR_W;

   //--------------------------------------------------------------
   // Burst order encoding and reset values
   //--------------------------------------------------------------
   localparam logic               ORDER_LINEAR = 1'h0;
   localparam logic [BURST_W-1:0] CNT_RESET    = 2'h0;
   localparam logic [BURST_W-1:0] CNT_STEP     = 2'h1;
   localparam logic [ADDR_W-1:0]  ADDR_RESET   = 19'h0;
   localparam logic [DATA_W-1:0]  DATA_RESET   = 36'h0;
   localparam logic [LANES-1:0]   BW_NONE_N    = 4'hf;

   //--------------------------------------------------------------
   // Test port timing
   //--------------------------------------------------------------
   localparam int CLK_NS          = 10;
   localparam int TEST_CLK_NS     = 100;
   localparam int TEST_CLK_CYC    = (TEST_CLK_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [2:0] TAP_RESET_EDGES = 3'h5;
   localparam logic [2:0] TAP_CNT_RESET   = 3'h0;

   //--------------------------------------------------------------
   // Operation carried down the pipeline (Gray along idle-read-write)
   //--------------------------------------------------------------
   typedef enum logic [1:0] {
      OP_IDLE  = 2'b00,
      OP_READ  = 2'b01,
      OP_WRITE = 2'b11
   } psb_op_e;

endpackage

// ---- rtl/psb_mem_if.sv ----
// Connection between the port pipeline and its storage array
`timescale 1ns/1ps
interface psb_mem_if;
   logic                          rdEn;
   logic [psb_pkg::ADDR_W-1:0]    rdAddr;
   logic [psb_pkg::DATA_W-1:0]    rdData;
   logic                          wrEn;
   logic [psb_pkg::ADDR_W-1:0]    wrAddr;
   logic [psb_pkg::LANES-1:0]     wrMask;
   logic [psb_pkg::DATA_W-1:0]    wrData;

   modport ctrl (output rdEn, rdAddr, wrEn, wrAddr, wrMask, wrData,
                 input  rdData);
   modport mem  (input  rdEn, rdAddr, wrEn, wrAddr, wrMask, wrData,
                 output rdData);
endinterface

// ---- rtl/psb_ram.sv ----
// Storage array with byte-lane writes and registered read data
`timescale 1ns/1ps
module psb_ram (
   input wire logic  clk,
   input wire logic  arst_n,
   psb_mem_if.mem    port
);

   logic [psb_pkg::DATA_W-1:0] ram [0:psb_pkg::DEPTH-1];
   logic [psb_pkg::DATA_W-1:0] rdData_r;

   //--------------------------------------------------------------
   // Array write, one enable per byte lane
   //--------------------------------------------------------------
   always_ff @(posedge clk) begin
      for (int i = 0; i < psb_pkg::LANES; i++) begin
         if (port.wrEn && port.wrMask[i]) begin
            ram[port.wrAddr][i*psb_pkg::LANE_W +: psb_pkg::LANE_W] <=
               port.wrData[i*psb_pkg::LANE_W +: psb_pkg::LANE_W];
         end
      end
   end

   //--------------------------------------------------------------
   // Read register, holds while no read is issued
   //--------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rdData_r <= psb_pkg::DATA_RESET;
      end else if (port.rdEn) begin
         rdData_r <= ram[port.rdAddr];
      end
   end

   assign port.rdData = rdData_r;

endmodule

// ---- rtl/psb_port.sv ----
// Pipelined burst SRAM port: control pipeline, burst counter, test port
//
// Functional notes
// - A burst advances only the two lowest address bits from the base.
// - Advance-or-load low ends any burst and loads new address, control.
// - While advancing, read/write is ignored; direction fixed at load.
// - Read/write low on a selected load cycle starts a write.
// - Byte-write selects qualify the data word two cycles later.
// - Clock gate high makes the edge absent; every register holds except the test port's.
// - Test port resets itself at power-up; test reset pin optional.
// - Test port runs at its own fixed rate, apart from the memory clock.
// - Read data for an address loaded at cycle n appears at n+2.
`timescale 1ns/1ps
module psb_port (
   input  wire logic                         clk,
   input  wire logic                         arst_n,
   input  wire logic [psb_pkg::ADDR_W-1:0]   address,
   input  wire logic                         readWrite,
   input  wire logic                         advanceOrLoad,
   input  wire logic                         clockGateN,
   input  wire logic                         chipSelectAN,
   input  wire logic                         chipSelectB,
   input  wire logic                         chipSelectCN,
   input  wire logic [psb_pkg::LANES-1:0]    byteWriteN,
   input  wire logic                         burstOrderSelect,
   input  wire logic [psb_pkg::DATA_W-1:0]   dataIn,
   output logic      [psb_pkg::DATA_W-1:0]   dataOut,
   output logic                              dataOe,
   input  wire logic                         testClk,
   input  wire logic                         testModeSel,
   input  wire logic                         testDataIn,
   input  wire logic                         testResetN,
   output logic                              testDataOut,
   output logic                              testInReset
);

   //--------------------------------------------------------------
   // Declarations
   //--------------------------------------------------------------
   psb_mem_if                     memBus ();
   logic                          run;
   logic                          selected;
   logic [1:0]                    lowBits;
   psb_pkg::psb_op_e              burstOp_r, burstOp_nxt;
   logic [psb_pkg::ADDR_W-1:0]    baseAddr_r, baseAddr_nxt;
   logic [psb_pkg::BURST_W-1:0]   burstCnt_r, burstCnt_nxt;
   psb_pkg::psb_op_e              s1Op_r, s1Op_nxt;
   logic [psb_pkg::ADDR_W-1:0]    s1Addr_r, s1Addr_nxt;
   logic [psb_pkg::LANES-1:0]     s1Bw_r, s1Bw_nxt;
   psb_pkg::psb_op_e              s2Op_r, s2Op_nxt;
   logic [psb_pkg::ADDR_W-1:0]    s2Addr_r, s2Addr_nxt;
   logic [psb_pkg::LANES-1:0]     s2Bw_r, s2Bw_nxt;
   logic                          fwdHit_r, fwdHit_nxt;
   logic [psb_pkg::DATA_W-1:0]    fwdData_r, fwdData_nxt;
   logic [psb_pkg::LANES-1:0]     fwdMask_r, fwdMask_nxt;
   logic [psb_pkg::DATA_W-1:0]    dataOut_r, dataOut_nxt;
   logic                          dataOe_r, dataOe_nxt;
   logic [psb_pkg::DATA_W-1:0]    mergedQ;

   // Gated edge and three-input chip select
   assign run      = !clockGateN;
   assign selected = !chipSelectAN && chipSelectB && !chipSelectCN;

   //--------------------------------------------------------------
   // Storage array
   //--------------------------------------------------------------
   psb_ram u_ram (
      .clk    (clk),
      .arst_n (arst_n),
      .port   (memBus.mem)
   );

   // Read in stage 1, write in stage 2 with the data on the bus
   assign memBus.rdEn   = run && (s1Op_r == psb_pkg::OP_READ);
   assign memBus.rdAddr = s1Addr_r;
   assign memBus.wrEn   = run && (s2Op_r == psb_pkg::OP_WRITE);
   assign memBus.wrAddr = s2Addr_r;
   assign memBus.wrMask = ~s2Bw_r;
   assign memBus.wrData = dataIn;

   // Per lane, a just-written byte overrides the stale array byte
   for (genvar i = 0; i < psb_pkg::LANES; i++) begin : g_merge
      assign mergedQ[i*psb_pkg::LANE_W +: psb_pkg::LANE_W] =
         (fwdHit_r && fwdMask_r[i]) ?
         fwdData_r[i*psb_pkg::LANE_W +: psb_pkg::LANE_W] :
         memBus.rdData[i*psb_pkg::LANE_W +: psb_pkg::LANE_W];
   end

   //--------------------------------------------------------------
   // Next state of burst counter and pipeline
   //--------------------------------------------------------------
   always_comb begin
      burstOp_nxt  = burstOp_r;
      baseAddr_nxt = baseAddr_r;
      burstCnt_nxt = burstCnt_r;
      s1Op_nxt     = s1Op_r;
      s1Addr_nxt   = s1Addr_r;
      s1Bw_nxt     = s1Bw_r;
      s2Op_nxt     = s2Op_r;
      s2Addr_nxt   = s2Addr_r;
      s2Bw_nxt     = s2Bw_r;
      fwdHit_nxt   = fwdHit_r;
      fwdData_nxt  = fwdData_r;
      fwdMask_nxt  = fwdMask_r;
      dataOut_nxt  = dataOut_r;
      dataOe_nxt   = dataOe_r;
      lowBits      = s1Addr_r[1:0];
      if (run) begin
         if (!advanceOrLoad) begin
            if (!selected) begin
               burstOp_nxt = psb_pkg::OP_IDLE;
            end else if (readWrite) begin
               burstOp_nxt = psb_pkg::OP_READ;
            end else begin
               burstOp_nxt = psb_pkg::OP_WRITE;
            end
            baseAddr_nxt = address;
            burstCnt_nxt = psb_pkg::CNT_RESET;
         end else begin
            // Direction stays as loaded; read/write not looked at
            burstCnt_nxt = burstCnt_r + psb_pkg::CNT_STEP;
         end
         if (burstOrderSelect == psb_pkg::ORDER_LINEAR) begin
            lowBits = baseAddr_nxt[1:0] + burstCnt_nxt;
         end else begin
            lowBits = baseAddr_nxt[1:0] ^ burstCnt_nxt;
         end
         s1Op_nxt   = burstOp_nxt;
         s1Addr_nxt = {baseAddr_nxt[psb_pkg::ADDR_W-1:2], lowBits};
         s1Bw_nxt   = byteWriteN;
         s2Op_nxt   = s1Op_r;
         s2Addr_nxt = s1Addr_r;
         s2Bw_nxt   = s1Bw_r;
         // Write committing now to the address being read now
         fwdHit_nxt  = (s1Op_r == psb_pkg::OP_READ) &&
                       (s2Op_r == psb_pkg::OP_WRITE) &&
                       (s1Addr_r == s2Addr_r);
         fwdData_nxt = dataIn;
         fwdMask_nxt = ~s2Bw_r;
         dataOe_nxt  = (s2Op_r == psb_pkg::OP_READ);
         if (s2Op_r == psb_pkg::OP_READ) begin
            dataOut_nxt = mergedQ;
         end
      end
   end

   //--------------------------------------------------------------
   // Pipeline registers
   //--------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         burstOp_r  <= psb_pkg::OP_IDLE;
         baseAddr_r <= psb_pkg::ADDR_RESET;
         burstCnt_r <= psb_pkg::CNT_RESET;
         s1Op_r     <= psb_pkg::OP_IDLE;
         s1Addr_r   <= psb_pkg::ADDR_RESET;
         s1Bw_r     <= psb_pkg::BW_NONE_N;
         s2Op_r     <= psb_pkg::OP_IDLE;
         s2Addr_r   <= psb_pkg::ADDR_RESET;
         s2Bw_r     <= psb_pkg::BW_NONE_N;
         fwdHit_r   <= 1'b0;
         fwdData_r  <= psb_pkg::DATA_RESET;
         fwdMask_r  <= '0;
         dataOut_r  <= psb_pkg::DATA_RESET;
         dataOe_r   <= 1'b0;
      end else begin
         burstOp_r  <= burstOp_nxt;
         baseAddr_r <= baseAddr_nxt;
         burstCnt_r <= burstCnt_nxt;
         s1Op_r     <= s1Op_nxt;
         s1Addr_r   <= s1Addr_nxt;
         s1Bw_r     <= s1Bw_nxt;
         s2Op_r     <= s2Op_nxt;
         s2Addr_r   <= s2Addr_nxt;
         s2Bw_r     <= s2Bw_nxt;
         fwdHit_r   <= fwdHit_nxt;
         fwdData_r  <= fwdData_nxt;
         fwdMask_r  <= fwdMask_nxt;
         dataOut_r  <= dataOut_nxt;
         dataOe_r   <= dataOe_nxt;
      end
   end

   assign dataOut = dataOut_r;
   assign dataOe  = dataOe_r;

   //--------------------------------------------------------------
   // Test port: own slow clock sampled, reset on power-up
   //--------------------------------------------------------------
   logic [3:0] tSync1_r, tSync2_r;
   logic       tckPrev_r, tckPrev_nxt;
   logic       tckRise;
   logic [2:0] tapCnt_r, tapCnt_nxt;
   logic       inReset_r, inReset_nxt;
   logic       bypass_r, bypass_nxt;
   logic       tdo_r, tdo_nxt;

   // Two-stage synchroniser for clock, mode, data, reset
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         tSync1_r <= 4'h0;
         tSync2_r <= 4'h0;
      end else begin
         tSync1_r <= {testResetN, testDataIn, testModeSel, testClk};
         tSync2_r <= tSync1_r;
      end
   end

   // Edge of the test clock, independent of memory clock gating
   assign tckRise = tSync2_r[0] && !tckPrev_r;

   // Bypass shift and five-edge mode-select reset
   always_comb begin
      tckPrev_nxt = tSync2_r[0];
      tapCnt_nxt  = tapCnt_r;
      inReset_nxt = inReset_r;
      bypass_nxt  = bypass_r;
      tdo_nxt     = tdo_r;
      if (tckRise) begin
         if (tSync2_r[1]) begin
            if (tapCnt_r != psb_pkg::TAP_RESET_EDGES) begin
               tapCnt_nxt = tapCnt_r + 3'h1;
            end
         end else begin
            tapCnt_nxt  = psb_pkg::TAP_CNT_RESET;
            inReset_nxt = 1'b0;
         end
         bypass_nxt = tSync2_r[2] && !inReset_r;
         tdo_nxt    = bypass_r;
      end
      if (!tSync2_r[3] || tapCnt_nxt == psb_pkg::TAP_RESET_EDGES) begin
         inReset_nxt = 1'b1;
      end
   end

   // Test port registers, held in reset from power-up
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         tckPrev_r <= 1'b0;
         tapCnt_r  <= psb_pkg::TAP_CNT_RESET;
         inReset_r <= 1'b1;
         bypass_r  <= 1'b0;
         tdo_r     <= 1'b0;
      end else begin
         tckPrev_r <= tckPrev_nxt;
         tapCnt_r  <= tapCnt_nxt;
         inReset_r <= inReset_nxt;
         bypass_r  <= bypass_nxt;
         tdo_r     <= tdo_nxt;
      end
   end

   assign testDataOut = tdo_r;
   assign testInReset = inReset_r;

   //--------------------------------------------------------------
   // Assertions
   //--------------------------------------------------------------
   a_gate_hold: assert property (
      @(posedge clk) disable iff (!arst_n)
      clockGateN |=> $stable(s1Addr_r) && $stable(burstCnt_r) &&
                     $stable(dataOut_r) && $stable(dataOe_r))
      else $error("State moved on a gated edge");

   a_load_base: assert property (
      @(posedge clk) disable iff (!arst_n)
      run && !advanceOrLoad |=> burstCnt_r == psb_pkg::CNT_RESET &&
                                baseAddr_r == $past(address))
      else $error("Load did not restart the burst");

   a_dir_fixed: assert property (
      @(posedge clk) disable iff (!arst_n)
      run && advanceOrLoad |=> s1Op_r == $past(s1Op_r))
      else $error("Burst direction changed while advancing");

   a_write_start: assert property (
      @(posedge clk) disable iff (!arst_n)
      run && !advanceOrLoad && selected && !readWrite
      |=> s1Op_r == psb_pkg::OP_WRITE ##1
          (!$past(run) || s2Op_r == psb_pkg::OP_WRITE))
      else $error("Selected load with write low did not start write");

   a_high_bits: assert property (
      @(posedge clk) disable iff (!arst_n)
      run |=> s1Addr_r[psb_pkg::ADDR_W-1:2] ==
         ($past(advanceOrLoad) ? $past(s1Addr_r[psb_pkg::ADDR_W-1:2]) :
          $past(address[psb_pkg::ADDR_W-1:2])))
      else $error("Burst touched address bits above the low two");

   a_burst_order: assert property (
      @(posedge clk) disable iff (!arst_n)
      run ##1 1'b1 |-> s1Addr_r[1:0] ==
         (($past(burstOrderSelect) == psb_pkg::ORDER_LINEAR) ?
          2'(baseAddr_r[1:0] + burstCnt_r) :
          (baseAddr_r[1:0] ^ burstCnt_r)))
      else $error("Burst low bits out of order");

   a_bw_pairing: assert property (
      @(posedge clk) disable iff (!arst_n)
      run ##1 run |=> s2Bw_r == $past(byteWriteN, 2))
      else $error("Byte selects not two cycles ahead of data");

   a_read_latency: assert property (
      @(posedge clk) disable iff (!arst_n)
      (run && !advanceOrLoad && selected && readWrite) ##1 run ##1 run
      |=> dataOe_r)
      else $error("Read data not driven two cycles after load");

   a_test_reset: assert property (
      @(posedge clk) disable iff (!arst_n)
      !tSync2_r[3] |=> inReset_r)
      else $error("Test port left reset while test reset low");

endmodule

// ---- tb/psb_host.sv ----
// Host controller model driving the burst SRAM port pins
`timescale 1ns/1ps
module psb_host (
   input  wire logic                       clk,
   input  wire logic                       arst_n,
   input  wire logic                       cmdAdv,
   input  wire logic                       cmdRw,
   input  wire logic                       cmdSel,
   input  wire logic                       cmdGateN,
   input  wire logic                       cmdOrder,
   input  wire logic [psb_pkg::ADDR_W-1:0] cmdAddr,
   input  wire logic [psb_pkg::LANES-1:0]  cmdBw,
   input  wire logic [psb_pkg::DATA_W-1:0] cmdData,
   output logic      [psb_pkg::ADDR_W-1:0] address,
   output logic                            readWrite,
   output logic                            advanceOrLoad,
   output logic                            clockGateN,
   output logic                            chipSelectAN,
   output logic                            chipSelectB,
   output logic                            chipSelectCN,
   output logic      [psb_pkg::LANES-1:0]  byteWriteN,
   output logic                            burstOrderSelect,
   output logic      [psb_pkg::DATA_W-1:0] dataIn
);
   logic                        burstWr;
   logic                        newWr;
   logic                        w1;
   logic                        w2;
   logic [psb_pkg::DATA_W-1:0]  d1;
   logic [psb_pkg::DATA_W-1:0]  d2;

   // Control pins follow the command, changed at the falling edge
   assign address          = cmdAddr;
   assign readWrite        = cmdRw;
   assign advanceOrLoad    = cmdAdv;
   assign clockGateN       = cmdGateN;
   assign burstOrderSelect = cmdOrder;
   assign byteWriteN       = cmdBw;         // Valid on every cycle
   assign chipSelectAN     = !cmdSel;       // Same timing, inverted
   assign chipSelectCN     = !cmdSel;
   assign chipSelectB      = cmdSel;
   assign newWr            = cmdSel && !cmdRw;

   // Write words trail their load by two ungated edges
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         burstWr <= 1'b0;
         w1      <= 1'b0;
         w2      <= 1'b0;
      end else if (!clockGateN) begin
         if (!advanceOrLoad)
            burstWr <= newWr;
         w1 <= advanceOrLoad ? burstWr : newWr; // Fixed at load
         d1 <= cmdData;
         w2 <= w1;
         d2 <= d1;
      end
   end

   // Unused data bus flips every cycle so stale words never match
   initial dataIn = psb_pkg::DATA_RESET;
   always @(negedge clk)
      dataIn <= w2 ? d2 : ~dataIn;
endmodule

// ---- tb/tb_top.sv ----
// Self-checking bench for the pipelined burst SRAM port
`timescale 1ns/1ps
module tb_top;
   localparam int HI = 19'h2a3c0;
   logic                        clk = 1'b0;
   logic                        arst_n = 1'b0;
   logic                        testClk = 1'b0;
   logic                        testDataIn = 1'b0;
   logic                        testResetN = 1'b1;
   logic                        testModeSel = 1'b0;
   logic                        testDataOut, tdoOn = 1'b0;
   logic                        byp = 1'b0, tdoExp = 1'b0;
   logic                        cmdAdv = 1'b0;
   logic                        cmdRw = 1'b1;
   logic                        cmdSel = 1'b0;
   logic                        cmdGateN = 1'b0;
   logic                        cmdOrder = 1'b0;
   logic [psb_pkg::ADDR_W-1:0]  cmdAddr = '0;
   logic [psb_pkg::LANES-1:0]   cmdBw = 4'hf;
   logic [psb_pkg::DATA_W-1:0]  cmdData = '0;
   logic [psb_pkg::ADDR_W-1:0]  address;
   logic                        readWrite, advanceOrLoad, clockGateN;
   logic                        chipSelectAN, chipSelectB, chipSelectCN;
   logic [psb_pkg::LANES-1:0]   byteWriteN;
   logic                        burstOrderSelect;
   logic [psb_pkg::DATA_W-1:0]  dataIn, dataOut, expD;
   logic                        dataOe, testInReset, expOe, checking = 1'b0;
   logic [psb_pkg::LANES-1:0]   bw1, bw2;
   logic [psb_pkg::DATA_W-1:0]  mem [int];
   int                          op1, op2, a1, a2, bop, base, cnt, low;
   int                          nErrors = 0, cmpCount = 0, cycles = 0;

   always #5 clk = ~clk;
   always #50 testClk = ~testClk;
   always @(negedge testClk)
      testDataIn <= 1'($urandom);

   psb_host u_host (
      .clk(clk), .arst_n(arst_n), .cmdAdv(cmdAdv), .cmdRw(cmdRw),
      .cmdSel(cmdSel), .cmdGateN(cmdGateN), .cmdOrder(cmdOrder),
      .cmdAddr(cmdAddr), .cmdBw(cmdBw), .cmdData(cmdData),
      .address(address), .readWrite(readWrite),
      .advanceOrLoad(advanceOrLoad), .clockGateN(clockGateN),
      .chipSelectAN(chipSelectAN), .chipSelectB(chipSelectB),
      .chipSelectCN(chipSelectCN), .byteWriteN(byteWriteN),
      .burstOrderSelect(burstOrderSelect), .dataIn(dataIn));

   psb_port u_dut (
      .clk(clk), .arst_n(arst_n), .address(address),
      .readWrite(readWrite), .advanceOrLoad(advanceOrLoad),
      .clockGateN(clockGateN), .chipSelectAN(chipSelectAN),
      .chipSelectB(chipSelectB), .chipSelectCN(chipSelectCN),
      .byteWriteN(byteWriteN), .burstOrderSelect(burstOrderSelect),
      .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe),
      .testClk(testClk), .testModeSel(testModeSel),
      .testDataIn(testDataIn), .testResetN(testResetN),
      .testDataOut(testDataOut), .testInReset(testInReset));

   // Compare a value and count the comparison
   task automatic check(input logic [psb_pkg::DATA_W-1:0] seen,
                        input logic [psb_pkg::DATA_W-1:0] exp);
      cmpCount++;
      if (seen !== exp) begin
         nErrors++;
         $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask

   // Verdict and end of run
   task automatic finish_test;
      if (nErrors == 0 && cmpCount > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // Bypass reference: one bit of delay per test clock rise
   always @(posedge testClk) begin
      tdoExp <= byp;
      byp    <= testDataIn && !testInReset;
   end

   // Test data out against reference, between test clock rises
   always @(negedge testClk)
      if (tdoOn)
         check(36'(testDataOut), 36'(tdoExp));

   // One bus cycle of the host, applied at the falling edge
   task automatic drive(input logic adv, input logic rw, input logic sel,
                        input logic gateN, input int ofs,
                        input logic [3:0] bw);
      @(negedge clk);
      cmdAdv   <= adv;
      cmdRw    <= rw;
      cmdSel   <= sel;
      cmdGateN <= gateN;
      cmdAddr  <= 19'(HI + ofs);
      cmdBw    <= bw;
      cmdData  <= 36'({$urandom, $urandom});
   endtask

   // Reference pipeline: data two ungated edges after its load
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         op1 = 0;
         op2 = 0;
         bop = 0;
         cnt = 0;
         base = 0;
         expOe = 1'b0;
      end else if (clockGateN === 1'b0) begin
         expOe = (op2 == 1);
         if (op2 == 1)
            expD = mem.exists(a2) ? mem[a2] : 'x;
         if (op2 == 2) begin
            if (!mem.exists(a2))
               mem[a2] = 'x;
            for (int i = 0; i < 4; i++)
               if (!bw2[i])
                  mem[a2][9*i +: 9] = dataIn[9*i +: 9];
         end
         if (!advanceOrLoad) begin
            bop = (chipSelectAN || !chipSelectB || chipSelectCN) ? 0 :
                  (readWrite ? 1 : 2);
            base = int'(address);
            cnt = 0;
         end else
            cnt = (cnt + 1) % 4;
         low = burstOrderSelect ? (base % 4) ^ cnt : (base % 4 + cnt) % 4;
         op2 = op1;
         a2 = a1;
         bw2 = bw1;
         op1 = bop;
         a1 = base - base % 4 + low;
         bw1 = byteWriteN;
      end
   end

   // Port against reference, once per cycle at the falling edge
   always @(negedge clk) begin
      if (arst_n && checking) begin
         check(36'(dataOe), 36'(expOe));
         if (expOe && !$isunknown(expD))
            check(dataOut, expD);
      end
   end

   // Hang guard
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         nErrors++;
         finish_test;
      end
   end

   initial begin
      void'($urandom(32'hc76f));
      repeat (12) @(negedge clk);
      check(36'(testInReset), 36'h1);
      arst_n = 1'b1;
      checking = 1'b1;
      tdoOn = 1'b1;
      // Fill sixteen words with four full-width write bursts
      for (int i = 0; i < 16; i++)
         drive(i % 4 != 0, 1'b0, 1'b1, 1'b0, i & 12, 4'h0);
      for (int o = 0; o < 2; o++) begin
         repeat (3) drive(1'b0, 1'b1, 1'b0, 1'b0, 0, 4'hf);
         cmdOrder <= o[0];
         // Read burst wrapping past four words, read/write toggled
         for (int i = 0; i < 6; i++)
            drive(i != 0, i == 0 || 1'($urandom), 1'b1, 1'b0, 5 + o, 4'hf);
         // Mixed loads, bursts, deselects, gated edges, partial writes
         for (int i = 0; i < 300; i++)
            drive($urandom % 3 != 0, 1'($urandom), $urandom % 6 != 0,
                  $urandom % 5 == 0, $urandom % 16, 4'($urandom));
      end
      // Test port left its own reset while clocked at its slow rate
      check(36'(testInReset), 36'h0);
      tdoOn = 1'b0;
      testResetN <= 1'b0;
      repeat (40) @(negedge clk);
      check(36'(testInReset), 36'h1);
      testResetN <= 1'b1;
      repeat (200) @(negedge clk);
      check(36'(testInReset), 36'h0);
      // Mode select high: three rises keep running, five force reset
      testModeSel <= 1'b1;
      repeat (35) @(negedge clk);
      check(36'(testInReset), 36'h0);
      repeat (35) @(negedge clk);
      check(36'(testInReset), 36'h1);
      testModeSel <= 1'b0;
      repeat (30) @(negedge clk);
      check(36'(testInReset), 36'h0);
      finish_test;
   end
endmodule
